// >>> core/ksio_pkg.sv
// Types shared by the key-scan port modules
package ksio_pkg;

    typedef enum logic [4:0] {
        KSIO_FN_PULL_IN  = 5'b00001,
        KSIO_FN_PURE_IN  = 5'b00010,
        KSIO_FN_OUT_LOW  = 5'b00100,
        KSIO_FN_OUT_HIGH = 5'b01000,
        KSIO_FN_FLOAT    = 5'b10000
    } ksio_fn_t;

    typedef enum logic [1:0] {
        KSIO_RUN   = 2'b01,
        KSIO_STBY  = 2'b10
    } ksio_pwr_t;

endpackage

// >>> core/ksio_port_ctl.sv
// Per-bit pad function decode for one port
module ksio_port_ctl #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    ksio_port_if.ctl p
);

    function automatic ksio_pkg::ksio_fn_t ksio_decode(input logic a, input logic d, input logic v);
        ksio_pkg::ksio_fn_t f;
        f = ksio_pkg::KSIO_FN_PURE_IN;
        case ({a, d, v})
            3'b000:  f = ksio_pkg::KSIO_FN_PULL_IN;  // RULE4
            3'b001:  f = ksio_pkg::KSIO_FN_PURE_IN;
            3'b010:  f = ksio_pkg::KSIO_FN_OUT_LOW;
            3'b011:  f = ksio_pkg::KSIO_FN_OUT_HIGH;
            3'b110:  f = ksio_pkg::KSIO_FN_FLOAT;
            default: f = ksio_pkg::KSIO_FN_PURE_IN;  // RULE5
        endcase
        return f;
    endfunction

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            ksio_pkg::ksio_fn_t fn;
            assign fn = ksio_decode(p.attr[i], p.dir[i], p.data[i]);  // RULE1

            // Pull-low is the reset state, so pads never float before software runs
            always_ff @(posedge clk) begin
                if (rst) begin
                    p.pin_out[i]     <= 1'b0;
                    p.pin_oe[i]      <= 1'b0;
                    p.pull_low_en[i] <= 1'b1;  // RULE2
                end else if (p.sf_en[i]) begin
                    p.pin_out[i]     <= p.sf_out[i];
                    p.pin_oe[i]      <= p.sf_oe[i];
                    p.pull_low_en[i] <= 1'b0;
                end else begin
                    p.pin_out[i]     <= (fn == ksio_pkg::KSIO_FN_OUT_HIGH);
                    p.pin_oe[i]      <= (fn == ksio_pkg::KSIO_FN_OUT_HIGH) ||
                                        (fn == ksio_pkg::KSIO_FN_OUT_LOW);
                    p.pull_low_en[i] <= (fn == ksio_pkg::KSIO_FN_PULL_IN);
                end
            end
        end
    endgenerate

endmodule

// >>> core/ksio_port_if.sv
// Per-port configuration and pad signals between the top and a port controller
interface ksio_port_if #(
    parameter int W = 8
);
    logic [W-1:0] attr;
    logic [W-1:0] dir;
    logic [W-1:0] data;
    logic [W-1:0] sf_en;
    logic [W-1:0] sf_oe;
    logic [W-1:0] sf_out;
    logic [W-1:0] pin_in;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;
    logic [W-1:0] pull_low_en;

    modport ctl (
        input  attr,
        input  dir,
        input  data,
        input  sf_en,
        input  sf_oe,
        input  sf_out,
        output pin_out,
        output pin_oe,
        output pull_low_en
    );

    modport top (
        output attr,
        output dir,
        output data,
        output sf_en,
        output sf_oe,
        output sf_out,
        input  pin_out,
        input  pin_oe,
        input  pull_low_en
    );
endinterface

// >>> core/ksio_regs.svh
// Register offsets, field positions, reset values and the behaviour summary of the key-scan ports
// Behaviour
// RULE1 - Three ports of four, six and eight bits, each bit configured independently.
// RULE2 - Initial reset puts every bit of every port into general-purpose input.
// RULE3 - Each port has data, direction and attribute register planes written by software.
// RULE4 - Codes 000 pull-low in, 001 pure in, 010 low, 011 high, 110 floating.
// RULE5 - Unlisted attribute/direction/data codes behave as pure input.
// RULE6 - Converter use: six-bit port bit 2 floating input, bits 5..3 pass-through outputs.
// RULE7 - Six-bit port bit 2 is the external interrupt source.
// RULE8 - Six-bit port bits 1 and 0 are shareable with two buzzer outputs.
// RULE9 - Control 0x16 bits 1,0 both one selects buzzer; both zero restores port.
// RULE10 - In buzzer mode each buzzer counter overflow toggles both buzzer pins.
// RULE11 - The eight-bit port is a wake-up source leaving stop-clock standby.
// RULE12 - During standby every pin keeps its configuration and output level; six-bit port bits 5..3 still follow conv_sensor_drive here.
// RULE13 - Wake-up alters no port register or pin; processor resumes after sleep.
// RULE14 - Wake event is any change of an enabled eight-bit input, synchronised first.
`ifndef KSIO_REGS_SVH
`define KSIO_REGS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define KSIO_NARROW_DATA 8'h00
`define KSIO_NARROW_DIR  8'h01
`define KSIO_NARROW_ATTR 8'h02
`define KSIO_MID_DATA    8'h03
`define KSIO_MID_DIR     8'h04
`define KSIO_MID_ATTR    8'h05
`define KSIO_WIDE_DATA   8'h06
`define KSIO_WIDE_DIR    8'h07
`define KSIO_WIDE_ATTR   8'h08
`define KSIO_STOP_CLK    8'h09
`define KSIO_WAKE_EN     8'h0a
`define KSIO_WAKE_STAT   8'h0b
`define KSIO_NARROW_PIN  8'h0c
`define KSIO_MID_PIN     8'h0d
`define KSIO_WIDE_PIN    8'h0e
`define KSIO_CONV_CTRL   8'h0f
`define KSIO_BUZZ_CTRL   8'h16
`define KSIO_BUZZ_RELOAD 8'h17

// ************************************************************
// Field positions
// ************************************************************
`define KSIO_STOP_BIT     0
`define KSIO_CONV_EN_BIT  0
`define KSIO_BUZZ_ON_CODE 2'b11
`define KSIO_BUZZ_OFF_CODE 2'b00
`define KSIO_EXT_BIT      2
`define KSIO_CONV_LO      3

// ************************************************************
// Reset values
// ************************************************************
`define KSIO_PLANE_RST    8'h00
`define KSIO_RELOAD_RST   8'h00

`endif

// >>> core/ksio_top.sv
// Key-scan port block: three configurable ports, buzzer share, converter share, port wake-up
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`include "ksio_regs.svh"

module ksio_top #(
    parameter int NARROW_W = 4,
    parameter int MID_W    = 6,
    parameter int WIDE_W   = 8
) (
    input  wire logic                clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [7:0]          addr,
    input  wire logic [7:0]          wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [7:0]          rdata,
    // Pads
    input  wire logic [NARROW_W-1:0] narrow_port_in,
    output logic      [NARROW_W-1:0] narrow_port_out,
    output logic      [NARROW_W-1:0] narrow_port_oe,
    output logic      [NARROW_W-1:0] narrow_port_pull_low,
    input  wire logic [MID_W-1:0]    mid_port_in,
    output logic      [MID_W-1:0]    mid_port_out,
    output logic      [MID_W-1:0]    mid_port_oe,
    output logic      [MID_W-1:0]    mid_port_pull_low,
    input  wire logic [WIDE_W-1:0]   wide_wake_port_in,
    output logic      [WIDE_W-1:0]   wide_wake_port_out,
    output logic      [WIDE_W-1:0]   wide_wake_port_oe,
    output logic      [WIDE_W-1:0]   wide_wake_port_pull_low,
    // Converter and interrupt side
    input  wire logic [2:0]          conv_sensor_drive,
    output logic                     ext_irq_conv_input,
    output logic                     conv_active,
    // Standby control
    input  wire logic                wake_other,
    output logic                     cpu_clk_stop,
    output logic                     wake_pulse
);

    // ************************************************************
    // Configuration planes
    // ************************************************************
    logic [NARROW_W-1:0] narrow_data_r, narrow_dir_r, narrow_attr_r;
    logic [MID_W-1:0]    mid_data_r, mid_dir_r, mid_attr_r;
    logic [WIDE_W-1:0]   wide_data_r, wide_dir_r, wide_attr_r;
    logic [WIDE_W-1:0]   wake_en_r;
    logic                wake_flag_r;
    logic                conv_en_r;
    logic [1:0]          buzz_ctrl_r;
    logic [7:0]          buzz_reload_r;
    logic                buzz_mode_r;
    logic [7:0]          buzz_cnt_r;
    logic                buzz_lvl_r;
    logic [7:0]          rdata_r;
    ksio_pkg::ksio_pwr_t pwr_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Software only writes while the processor runs; in standby nothing here moves
    always_ff @(posedge clk) begin
        if (rst) begin
            narrow_data_r <= NARROW_W'(`KSIO_PLANE_RST);  // RULE2
            narrow_dir_r  <= NARROW_W'(`KSIO_PLANE_RST);
            narrow_attr_r <= NARROW_W'(`KSIO_PLANE_RST);
            mid_data_r    <= MID_W'(`KSIO_PLANE_RST);
            mid_dir_r     <= MID_W'(`KSIO_PLANE_RST);
            mid_attr_r    <= MID_W'(`KSIO_PLANE_RST);
            wide_data_r   <= WIDE_W'(`KSIO_PLANE_RST);
            wide_dir_r    <= WIDE_W'(`KSIO_PLANE_RST);
            wide_attr_r   <= WIDE_W'(`KSIO_PLANE_RST);
        end else if (wr) begin
            if (hit(addr, `KSIO_NARROW_DATA)) narrow_data_r <= wdata[NARROW_W-1:0];  // RULE3
            if (hit(addr, `KSIO_NARROW_DIR))  narrow_dir_r  <= wdata[NARROW_W-1:0];
            if (hit(addr, `KSIO_NARROW_ATTR)) narrow_attr_r <= wdata[NARROW_W-1:0];
            if (hit(addr, `KSIO_MID_DATA))    mid_data_r    <= wdata[MID_W-1:0];
            if (hit(addr, `KSIO_MID_DIR))     mid_dir_r     <= wdata[MID_W-1:0];
            if (hit(addr, `KSIO_MID_ATTR))    mid_attr_r    <= wdata[MID_W-1:0];
            if (hit(addr, `KSIO_WIDE_DATA))   wide_data_r   <= wdata[WIDE_W-1:0];
            if (hit(addr, `KSIO_WIDE_DIR))    wide_dir_r    <= wdata[WIDE_W-1:0];
            if (hit(addr, `KSIO_WIDE_ATTR))   wide_attr_r   <= wdata[WIDE_W-1:0];
        end
    end

    // ************************************************************
    // Function controls
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_en_r     <= 1'b0;
            buzz_ctrl_r   <= 2'b00;
            buzz_reload_r <= `KSIO_RELOAD_RST;
            wake_en_r     <= '0;
        end else if (wr) begin
            if (hit(addr, `KSIO_CONV_CTRL))   conv_en_r     <= wdata[`KSIO_CONV_EN_BIT];
            if (hit(addr, `KSIO_BUZZ_CTRL))   buzz_ctrl_r   <= wdata[1:0];
            if (hit(addr, `KSIO_BUZZ_RELOAD)) buzz_reload_r <= wdata;
            if (hit(addr, `KSIO_WAKE_EN))     wake_en_r     <= wdata[WIDE_W-1:0];
        end
    end

    // Mixed codes 01 and 10 keep the current mode rather than guess
    always_ff @(posedge clk) begin
        if (rst) begin
            buzz_mode_r <= 1'b0;
        end else if (buzz_ctrl_r == `KSIO_BUZZ_ON_CODE) begin
            buzz_mode_r <= 1'b1;  // RULE9
        end else if (buzz_ctrl_r == `KSIO_BUZZ_OFF_CODE) begin
            buzz_mode_r <= 1'b0;  // RULE9
        end
    end

    // ************************************************************
    // Buzzer counter
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst || !buzz_mode_r) begin
            buzz_cnt_r <= buzz_reload_r;
            buzz_lvl_r <= 1'b0;
        end else if (cpu_clk_stop) begin
            // Frozen so the buzzer pins keep their level in standby
            buzz_cnt_r <= buzz_cnt_r;  // RULE12
        end else if (buzz_cnt_r == 8'hff) begin
            buzz_cnt_r <= buzz_reload_r;
            buzz_lvl_r <= ~buzz_lvl_r;  // RULE10
        end else begin
            buzz_cnt_r <= buzz_cnt_r + 8'h01;
        end
    end

    // ************************************************************
    // Port controllers
    // ************************************************************
    ksio_port_if #(.W(NARROW_W)) narrow_if ();
    ksio_port_if #(.W(MID_W))    mid_if ();
    ksio_port_if #(.W(WIDE_W))   wide_if ();

    assign narrow_if.attr   = narrow_attr_r;
    assign narrow_if.dir    = narrow_dir_r;
    assign narrow_if.data   = narrow_data_r;
    assign narrow_if.sf_en  = '0;
    assign narrow_if.sf_oe  = '0;
    assign narrow_if.sf_out = '0;
    assign narrow_if.pin_in = narrow_port_in;

    assign wide_if.attr   = wide_attr_r;
    assign wide_if.dir    = wide_dir_r;
    assign wide_if.data   = wide_data_r;
    assign wide_if.sf_en  = '0;
    assign wide_if.sf_oe  = '0;
    assign wide_if.sf_out = '0;
    assign wide_if.pin_in = wide_wake_port_in;

    assign mid_if.attr   = mid_attr_r;
    assign mid_if.dir    = mid_dir_r;
    assign mid_if.data   = mid_data_r;
    assign mid_if.pin_in = mid_port_in;

    // Special functions override the planes bit by bit
    always_comb begin
        mid_if.sf_en  = '0;
        mid_if.sf_oe  = '0;
        mid_if.sf_out = '0;
        if (conv_en_r) begin
            mid_if.sf_en[`KSIO_EXT_BIT]                 = 1'b1;  // RULE6
            mid_if.sf_en[`KSIO_CONV_LO +: 3]            = 3'b111;
            mid_if.sf_oe[`KSIO_CONV_LO +: 3]            = 3'b111;
            mid_if.sf_out[`KSIO_CONV_LO +: 3]           = conv_sensor_drive;  // RULE6
        end
        if (buzz_mode_r) begin
            mid_if.sf_en[1:0]  = 2'b11;  // RULE8
            mid_if.sf_oe[1:0]  = 2'b11;
            mid_if.sf_out[1:0] = {~buzz_lvl_r, buzz_lvl_r};  // RULE10
        end
    end

    ksio_port_ctl #(.W(NARROW_W)) u_narrow (
        .clk (clk),
        .rst (rst),
        .p   (narrow_if)
    );

    ksio_port_ctl #(.W(MID_W)) u_mid (
        .clk (clk),
        .rst (rst),
        .p   (mid_if)
    );

    ksio_port_ctl #(.W(WIDE_W)) u_wide (
        .clk (clk),
        .rst (rst),
        .p   (wide_if)
    );

    assign narrow_port_out         = narrow_if.pin_out;
    assign narrow_port_oe          = narrow_if.pin_oe;
    assign narrow_port_pull_low    = narrow_if.pull_low_en;
    assign mid_port_out            = mid_if.pin_out;
    assign mid_port_oe             = mid_if.pin_oe;
    assign mid_port_pull_low       = mid_if.pull_low_en;
    assign wide_wake_port_out      = wide_if.pin_out;
    assign wide_wake_port_oe       = wide_if.pin_oe;
    assign wide_wake_port_pull_low = wide_if.pull_low_en;
    assign conv_active             = conv_en_r;

    // Level handed to the interrupt controller and converter oscillator
    logic ext_irq_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_irq_r <= 1'b0;
        end else begin
            ext_irq_r <= mid_if.pin_in[`KSIO_EXT_BIT];  // RULE7
        end
    end
    assign ext_irq_conv_input = ext_irq_r;

    // ************************************************************
    // Wake detection
    // ************************************************************
    // Keys bounce and are asynchronous in practice, so two flops guard the edge detect
    logic [WIDE_W-1:0] wake_s1_r, wake_s2_r, wake_s3_r;
    logic              wake_evt;

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_s1_r <= '0;
            wake_s2_r <= '0;
            wake_s3_r <= '0;
        end else begin
            wake_s1_r <= wide_if.pin_in;  // RULE14
            wake_s2_r <= wake_s1_r;
            wake_s3_r <= wake_s2_r;
        end
    end

    assign wake_evt = |((wake_s2_r ^ wake_s3_r) & wake_en_r);  // RULE11

    // Status set by a change wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_flag_r <= 1'b0;
        end else if (wake_evt) begin
            wake_flag_r <= 1'b1;  // RULE14
        end else if (wr && hit(addr, `KSIO_WAKE_STAT) && wdata[0]) begin
            wake_flag_r <= 1'b0;
        end
    end

    // ************************************************************
    // Standby
    // ************************************************************
    logic stop_req;
    logic wake_any;
    assign stop_req = wr && hit(addr, `KSIO_STOP_CLK) && wdata[`KSIO_STOP_BIT];
    assign wake_any = wake_evt || wake_other;

    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_r      <= ksio_pkg::KSIO_RUN;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            case (pwr_r)
                ksio_pkg::KSIO_RUN: begin
                    if (stop_req) begin
                        pwr_r <= ksio_pkg::KSIO_STBY;  // RULE12
                    end
                end
                ksio_pkg::KSIO_STBY: begin
                    // Only the clock request and wake_pulse change; planes and pads are untouched
                    if (wake_any) begin
                        pwr_r      <= ksio_pkg::KSIO_RUN;  // RULE13
                        wake_pulse <= 1'b1;
                    end
                end
                default: begin
                    pwr_r <= ksio_pkg::KSIO_RUN;
                end
            endcase
        end
    end

    assign cpu_clk_stop = (pwr_r == ksio_pkg::KSIO_STBY);

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            case (addr)
                `KSIO_NARROW_DATA: rdata_r <= 8'(narrow_data_r);
                `KSIO_NARROW_DIR:  rdata_r <= 8'(narrow_dir_r);
                `KSIO_NARROW_ATTR: rdata_r <= 8'(narrow_attr_r);
                `KSIO_MID_DATA:    rdata_r <= 8'(mid_data_r);
                `KSIO_MID_DIR:     rdata_r <= 8'(mid_dir_r);
                `KSIO_MID_ATTR:    rdata_r <= 8'(mid_attr_r);
                `KSIO_WIDE_DATA:   rdata_r <= 8'(wide_data_r);
                `KSIO_WIDE_DIR:    rdata_r <= 8'(wide_dir_r);
                `KSIO_WIDE_ATTR:   rdata_r <= 8'(wide_attr_r);
                `KSIO_STOP_CLK:    rdata_r <= {7'h00, cpu_clk_stop};
                `KSIO_WAKE_EN:     rdata_r <= 8'(wake_en_r);
                `KSIO_WAKE_STAT:   rdata_r <= {7'h00, wake_flag_r};
                `KSIO_NARROW_PIN:  rdata_r <= 8'(narrow_if.pin_in);
                `KSIO_MID_PIN:     rdata_r <= 8'(mid_port_in);
                `KSIO_WIDE_PIN:    rdata_r <= 8'(wide_wake_port_in);
                `KSIO_CONV_CTRL:   rdata_r <= {7'h00, conv_en_r};
                `KSIO_BUZZ_CTRL:   rdata_r <= {6'h00, buzz_ctrl_r};
                `KSIO_BUZZ_RELOAD: rdata_r <= buzz_reload_r;
                default:           rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata = rdata_r;

endmodule

// >>> tb/ksio_pad_model.sv
// Pad-side model: keys and sensors on one port, resolved against the block's drive
module ksio_pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    input  wire logic [W-1:0] pad_pull_low,
    input  wire logic [W-1:0] keys,
    output logic      [W-1:0] pin
);
    timeunit 1ns / 1ps;
    // Driven bits win; a pulled-low bit reads 0 even with a key closed
    assign pin = (pad_out & pad_oe) | (keys & ~pad_oe & ~pad_pull_low);
endmodule

// >>> tb/ksio_top_chk.sv
// Concurrent checks on the key-scan port block pins
module ksio_top_chk #(
    parameter int NARROW_W = 4,
    parameter int MID_W    = 6,
    parameter int WIDE_W   = 8
) (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [7:0]          addr,
    input wire logic [7:0]          wdata,
    input wire logic                wr,
    input wire logic                rd,
    input wire logic [7:0]          rdata,
    input wire logic [NARROW_W-1:0] narrow_port_oe,
    input wire logic [MID_W-1:0]    mid_port_in,
    input wire logic [MID_W-1:0]    mid_port_out,
    input wire logic [MID_W-1:0]    mid_port_oe,
    input wire logic [MID_W-1:0]    mid_port_pull_low,
    input wire logic [WIDE_W-1:0]   wide_wake_port_out,
    input wire logic [WIDE_W-1:0]   wide_wake_port_oe,
    input wire logic [2:0]          conv_sensor_drive,
    input wire logic                ext_irq_conv_input,
    input wire logic                conv_active,
    input wire logic                wake_other,
    input wire logic                cpu_clk_stop,
    input wire logic                wake_pulse
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge clk);
    endclocking

    sequence conv_held_s;
        conv_active ##1 conv_active;
    endsequence
    sequence stby_held_s;
        cpu_clk_stop ##1 cpu_clk_stop;
    endsequence

    reset_pads_a: assert property (rst |=> mid_port_oe == '0 && mid_port_pull_low == '1
        && wide_wake_port_oe == '0 && !cpu_clk_stop && rdata == 8'h00)
        else $error("pads not inputs after reset");
    rdata_idle_a: assert property (disable iff (rst) !rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    pin_read_a: assert property (disable iff (rst) rd && addr == 8'h0d
        |=> rdata == {2'b00, $past(mid_port_in)})
        else $error("mid pin read wrong");
    stop_entry_a: assert property (disable iff (rst) wr && addr == 8'h09 && wdata[0]
        |=> cpu_clk_stop)
        else $error("standby not entered");
    wake_other_a: assert property (disable iff (rst) cpu_clk_stop && wake_other
        |=> !cpu_clk_stop && wake_pulse)
        else $error("timer wake ignored");
    wake_pulse_a: assert property (disable iff (rst) wake_pulse
        |-> $fell(cpu_clk_stop) ##1 !wake_pulse)
        else $error("wake pulse wrong");
    stby_hold_a: assert property (disable iff (rst) stby_held_s
        |-> $stable(narrow_port_oe) && $stable(mid_port_oe) && $stable(wide_wake_port_oe)
        && $stable(wide_wake_port_out) && $stable(mid_port_pull_low))
        else $error("pads moved in standby");
    conv_pads_a: assert property (disable iff (rst) conv_held_s
        |-> mid_port_oe[5:2] == 4'b1110 && !mid_port_pull_low[2]
        && mid_port_out[5:3] == $past(conv_sensor_drive))
        else $error("converter pads wrong");
    ext_copy_a: assert property (disable iff (rst) 1'b1
        |=> ext_irq_conv_input == $past(mid_port_in[2]))
        else $error("interrupt input not following pin");
endmodule

bind ksio_top ksio_top_chk #(.NARROW_W(NARROW_W), .MID_W(MID_W), .WIDE_W(WIDE_W)) i_ksio_top_chk (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .narrow_port_oe, .mid_port_in, .mid_port_out,
    .mid_port_oe, .mid_port_pull_low, .wide_wake_port_out, .wide_wake_port_oe,
    .conv_sensor_drive, .ext_irq_conv_input, .conv_active, .wake_other, .cpu_clk_stop,
    .wake_pulse);

// >>> tb/ksio_top_tb.sv
// Self-checking bench for the key-scan port block
`include "ksio_regs.svh"

module ksio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, wr, rd, wake_other, ext_irq, conv_on, stop, wake;
    logic [7:0] addr, wdata, rdata, w_keys, w_in, w_out, w_oe, w_pl;
    logic [5:0] m_keys, m_in, m_out, m_oe, m_pl;
    logic [3:0] n_keys, n_in, n_out, n_oe, n_pl;
    logic [2:0] drive;
    int         fails, checks, cycles, n;

    ksio_top i_ksio_top (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .narrow_port_in(n_in), .narrow_port_out(n_out), .narrow_port_oe(n_oe),
        .narrow_port_pull_low(n_pl), .mid_port_in(m_in), .mid_port_out(m_out),
        .mid_port_oe(m_oe), .mid_port_pull_low(m_pl), .wide_wake_port_in(w_in),
        .wide_wake_port_out(w_out), .wide_wake_port_oe(w_oe), .wide_wake_port_pull_low(w_pl),
        .conv_sensor_drive(drive), .ext_irq_conv_input(ext_irq), .conv_active(conv_on),
        .wake_other, .cpu_clk_stop(stop), .wake_pulse(wake));
    ksio_pad_model #(.W(4)) i_ksio_pad_model_n (.pad_out(n_out), .pad_oe(n_oe),
        .pad_pull_low(n_pl), .keys(n_keys), .pin(n_in));
    ksio_pad_model #(.W(6)) i_ksio_pad_model_m (.pad_out(m_out), .pad_oe(m_oe),
        .pad_pull_low(m_pl), .keys(m_keys), .pin(m_in));
    ksio_pad_model #(.W(8)) i_ksio_pad_model_w (.pad_out(w_out), .pad_oe(w_oe),
        .pad_pull_low(w_pl), .keys(w_keys), .pin(w_in));

    // ****************
    // Access tasks
    // ****************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    // Skips one partial interval so the count starts on a toggle
    task automatic buzz_gap(output int g);
        logic last;
        repeat (2) begin
            last = m_out[0];
            g = 0;
            while (m_out[0] === last && g < 40) begin
                @(negedge clk);
                g++;
            end
        end
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        rst        = 1'b1;
        wr         = 1'b0;
        rd         = 1'b0;
        addr       = 8'h00;
        wdata      = 8'h00;
        wake_other = 1'b0;
        drive      = 3'h5;
        w_keys     = 8'ha5;
        m_keys     = 6'h2a;
        n_keys     = 4'h9;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1 chk("pull_low", 8'hff, w_pl);
        chk("oe", 8'h00, {w_oe[3:0], n_oe});
        for (int a = 0; a < 9; a++) chk_rd("plane", a[7:0], 8'h00);
        // Wide bit i gets code i; narrow bit i gets code i+4
        wr_reg(`KSIO_WIDE_DATA, 8'haa);
        wr_reg(`KSIO_WIDE_DIR, 8'hcc);
        wr_reg(`KSIO_WIDE_ATTR, 8'hf0);
        wr_reg(`KSIO_NARROW_DATA, 8'h0a);
        wr_reg(`KSIO_NARROW_DIR, 8'h0c);
        wr_reg(`KSIO_NARROW_ATTR, 8'h0f);
        repeat (3) @(posedge clk);
        #1 chk("wide_oe", 8'h0c, w_oe);
        chk("wide_out", 8'h08, w_out & w_oe);
        chk("wide_pull", 8'h01, w_pl);
        chk("narrow_cfg", 8'h00, {n_oe, n_pl} | {n_out, 4'h0});
        chk_rd("wide_dir", `KSIO_WIDE_DIR, 8'hcc);
        chk_rd("wide_pin", `KSIO_WIDE_PIN, 8'ha8);
        chk_rd("narrow_pin", `KSIO_NARROW_PIN, 8'h09);
        chk_rd("unmapped", 8'h30, 8'h00);
        wr_reg(`KSIO_MID_DIR, 8'h3f);
        wr_reg(`KSIO_MID_DATA, 8'h15);
        wr_reg(`KSIO_CONV_CTRL, 8'h01);
        m_keys[2] <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("conv_oe", 8'h3b, {1'b0, ~conv_on, m_oe});
        chk("conv_out", 8'h29, {2'b00, m_out & m_oe});
        chk("ext_irq", 8'h01, {7'h00, ext_irq});
        chk_rd("mid_pin", `KSIO_MID_PIN, 8'h2d);
        wr_reg(`KSIO_CONV_CTRL, 8'h00);
        // Reload 0xfc gives four cycles between toggles
        wr_reg(`KSIO_BUZZ_RELOAD, 8'hfc);
        wr_reg(`KSIO_BUZZ_CTRL, 8'h03);
        buzz_gap(n);
        chk("buzz_gap", 8'h04, n[7:0]);
        #1 chk("buzz_pins", 8'h07, {5'h00, m_oe[1:0], m_out[1] ^ m_out[0]});
        wr_reg(`KSIO_BUZZ_CTRL, 8'h01);
        buzz_gap(n);
        chk("buzz_hold", 8'h04, n[7:0]);
        wr_reg(`KSIO_BUZZ_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk("buzz_off", 8'h01, {6'h00, m_out[1:0]});
        wr_reg(`KSIO_WAKE_EN, 8'h02);
        wr_reg(`KSIO_STOP_CLK, 8'h01);
        w_keys[7] <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk("no_wake", 8'h01, {7'h00, stop});
        chk("stby_oe", 8'h0c, w_oe);
        w_keys[1] <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("key_wake", 8'h00, {7'h00, stop});
        chk("wake_oe", 8'h0c, w_oe);
        chk_rd("wake_flag", `KSIO_WAKE_STAT, 8'h01);
        wr_reg(`KSIO_WAKE_STAT, 8'h01);
        chk_rd("flag_clear", `KSIO_WAKE_STAT, 8'h00);
        chk_rd("wake_dir", `KSIO_WIDE_DIR, 8'hcc);
        wr_reg(`KSIO_STOP_CLK, 8'h01);
        repeat (2) @(posedge clk);
        wake_other <= 1'b1;
        @(posedge clk);
        wake_other <= 1'b0;
        #1 chk("other_wake", 8'h02, {6'h00, wake, stop});
        summarize();
    end
endmodule
